// [hdl/mlsc_low_speed_ctrl.sv]
// Top of the module's low-speed management and control logic.
`timescale 1ns/100ps
// Contract
// - Serial bus transactions are answered only while module select is held low.
// - Serial clock and data give host read and write access to memory map.
// - Reset pin held low past minimum width restores every setting to default.
// - Completion is shown by asserting interrupt and clearing status-not-valid.
// - After power-up the completion interrupt comes without any host reset.
// - Low-power input high switches every laser off.
// - Transmitter is disabled by the hardware input, the serial command, or both.
// - Loss-of-signal alarm rises when any lane's received power drops below threshold.
// - Interrupt output drives low while a receive loss-of-signal is present.
// - No other alarm reaches the interrupt output; they stay in memory map.
// - Each lane's received power is monitored and readable over serial bus.
// - Presence line is tied low so the host sees the module present.
module mlsc_low_speed_ctrl
  import mlsc_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    sclIn,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOeN,
  input  wire logic                    moduleSelectN,
  input  wire logic                    moduleResetN,
  input  wire logic                    lowPowerLaserOff,
  output logic                         presenceN,
  output logic                         interruptOutN,
  output logic [LANES-1:0]             laserOff,
  output logic [LANES-1:0]             receiveSignalLost,
  input  wire mlsc_power_t [LANES-1:0] rxPower,
  input  wire mlsc_power_t             losAssertLevel,
  input  wire mlsc_power_t             losDeassertLevel
);

  mlsc_pins_t               pinsRaw;
  mlsc_pins_t               pins;
  mlsc_power_t [LANES-1:0]  powerHeld;
  logic                     sclPrev_q;
  logic                     sdaPrev_q;
  logic                     sclRise;
  logic                     sclFall;
  logic                     startCond;
  logic                     stopCond;
  logic                     fsmActive;
  logic [RESET_CNT_W-1:0]   resetLowCnt_q;
  logic                     moduleReset;
  logic                     initBusy_q;
  logic [INIT_CNT_W-1:0]    initCnt_q;
  logic                     initDone;
  logic                     intPending_q;
  mlsc_bus_state_t          state_q;
  logic [3:0]               bitCnt_q;
  logic [7:0]               shift_q;
  logic [7:0]               ptr_q;
  logic                     rnw_q;
  logic                     nack_q;
  logic                     firstWr_q;
  logic                     sdaLow_q;
  logic [7:0]               readByte;
  logic                     loadRead;
  logic                     wrByteDone;
  logic                     rdByteDone;
  logic                     statusRead;
  logic [LANES-1:0]         transmitDisable_q;
  logic [LANES-1:0][7:0]    lsbHold_q;
  logic                     losAny;

  // All pins from the host board pass the synchroniser before any logic looks at them.
  assign pinsRaw.scl      = sclIn;
  assign pinsRaw.sda      = sdaIn;
  assign pinsRaw.selectN  = moduleSelectN;
  assign pinsRaw.resetN   = moduleResetN;
  assign pinsRaw.lowPower = lowPowerLaserOff;

  mlsc_pin_sync uPinSync (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .pinsRaw    (pinsRaw),
    .pinsStable (pins)
  );

  mlsc_diagnostic_monitor uMonitor (
    .sys_clk          (sys_clk),
    .rst_b            (rst_b),
    .rxPower          (rxPower),
    .losAssertLevel   (losAssertLevel),
    .losDeassertLevel (losDeassertLevel),
    .powerHeld        (powerHeld),
    .laneLost         (receiveSignalLost)
  );

  // The presence line is a plain ground path on the module side.
  assign presenceN = 1'b0;

  // The data line is open drain: the level driven is always low, the enable decides.
  assign sdaOut = 1'b0;
  assign sdaOeN = ~sdaLow_q;

  // Bus edges, start and stop, all taken from the filtered pin levels.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= pins.scl;
      sdaPrev_q <= pins.sda;
    end
  end

  assign sclRise   = pins.scl & ~sclPrev_q;
  assign sclFall   = ~pins.scl & sclPrev_q;
  assign startCond = pins.scl & sclPrev_q & sdaPrev_q & ~pins.sda;
  assign stopCond  = pins.scl & sclPrev_q & ~sdaPrev_q & pins.sda;
  assign fsmActive = ~pins.selectN & ~startCond & ~stopCond;

  // Count how long the reset pin has been low; short dips below the minimum do nothing.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      resetLowCnt_q <= '0;
    end else if (pins.resetN) begin
      resetLowCnt_q <= '0;
    end else if (resetLowCnt_q != RESET_CNT_W'(RESET_MIN_CYC)) begin
      resetLowCnt_q <= resetLowCnt_q + RESET_CNT_W'(1);
    end
  end

  assign moduleReset = (resetLowCnt_q == RESET_CNT_W'(RESET_MIN_CYC));

  // Settling period after power-up or a pin reset; status reads as not valid meanwhile.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      initBusy_q <= 1'b1;
      initCnt_q  <= '0;
    end else if (moduleReset) begin
      initBusy_q <= 1'b1;
      initCnt_q  <= '0;
    end else if (initBusy_q) begin
      if (initCnt_q == INIT_CNT_W'(INIT_CYC - 1)) begin
        initBusy_q <= 1'b0;
      end else begin
        initCnt_q <= initCnt_q + INIT_CNT_W'(1);
      end
    end
  end

  assign initDone = initBusy_q & ~moduleReset & (initCnt_q == INIT_CNT_W'(INIT_CYC - 1));

  // Completion interrupt stays until the host reads status or a pin reset takes effect; a new completion wins the read.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      intPending_q <= 1'b0;
    end else if (initDone) begin
      intPending_q <= 1'b1;
    end else if (moduleReset || statusRead) begin
      intPending_q <= 1'b0;
    end
  end

  // Only loss of signal and reset completion pull the pin; other alarms stay in the map.
  assign losAny = |receiveSignalLost;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      interruptOutN <= 1'b1;
    end else begin
      interruptOutN <= ~(losAny | intPending_q);
    end
  end

  // Either disable source turns a lane's laser off.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      laserOff <= LASER_OFF_RESET;
    end else begin
      laserOff <= transmitDisable_q | {LANES{pins.lowPower}};
    end
  end

  // Strobes shared by the bus state machine and the memory map.
  assign loadRead   = fsmActive & sclFall &
                      (((state_q == BUS_ACKDEV) & rnw_q) | ((state_q == BUS_ACKRD) & ~nack_q));
  assign wrByteDone = fsmActive & sclFall & (state_q == BUS_WRBYTE) & (bitCnt_q == BYTE_BITS);
  assign rdByteDone = fsmActive & sclFall & (state_q == BUS_RDBYTE) & (bitCnt_q == BYTE_BITS);
  assign statusRead = loadRead & (ptr_q == REG_STATUS);

  // Two-wire slave. Deselect or stop drops everything and lets the data line go.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q  <= BUS_IDLE;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
      rnw_q    <= 1'b0;
      nack_q   <= 1'b0;
      sdaLow_q <= 1'b0;
    end else if (pins.selectN || stopCond) begin
      state_q  <= BUS_IDLE;
      sdaLow_q <= 1'b0;
    end else if (startCond) begin
      state_q  <= BUS_DEVADR;
      bitCnt_q <= 4'h0;
      sdaLow_q <= 1'b0;
    end else begin
      unique case (state_q)
        BUS_IDLE: begin
        end
        BUS_DEVADR, BUS_WRBYTE: begin
          if (sclRise) begin
            shift_q  <= {shift_q[6:0], pins.sda};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == BYTE_BITS) begin
            bitCnt_q <= 4'h0;
            if (state_q == BUS_WRBYTE) begin
              state_q  <= BUS_ACKWR;
              sdaLow_q <= 1'b1;
            end else if (shift_q[7:1] == DEV_ADDR) begin
              state_q  <= BUS_ACKDEV;
              sdaLow_q <= 1'b1;
              rnw_q    <= shift_q[0];
            end else begin
              state_q <= BUS_IDLE;
            end
          end
        end
        BUS_ACKDEV, BUS_ACKRD: begin
          if (sclRise) begin
            nack_q <= pins.sda;
          end else if (sclFall) begin
            if (state_q == BUS_ACKRD && nack_q) begin
              state_q  <= BUS_IDLE;
              sdaLow_q <= 1'b0;
            end else if (state_q == BUS_ACKRD || rnw_q) begin
              state_q  <= BUS_RDBYTE;
              shift_q  <= readByte;
              sdaLow_q <= ~readByte[7];
            end else begin
              state_q  <= BUS_WRBYTE;
              sdaLow_q <= 1'b0;
            end
          end
        end
        BUS_ACKWR: begin
          if (sclFall) begin
            state_q  <= BUS_WRBYTE;
            sdaLow_q <= 1'b0;
          end
        end
        BUS_RDBYTE: begin
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_q == BYTE_BITS) begin
              state_q  <= BUS_ACKRD;
              bitCnt_q <= 4'h0;
              sdaLow_q <= 1'b0;
            end else begin
              shift_q  <= {shift_q[6:0], 1'b0};
              sdaLow_q <= ~shift_q[6];
            end
          end
        end
        default: begin
          state_q  <= BUS_IDLE;
          sdaLow_q <= 1'b0;
        end
      endcase
    end
  end

  // Address pointer: first written byte sets it, every data byte moves it on by one.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q     <= 8'h00;
      firstWr_q <= 1'b0;
    end else if (fsmActive && sclFall && state_q == BUS_ACKDEV && !rnw_q) begin
      firstWr_q <= 1'b1;
    end else if (wrByteDone) begin
      firstWr_q <= 1'b0;
      ptr_q     <= firstWr_q ? shift_q : ptr_q + 8'h01;
    end else if (rdByteDone) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // Software disable bits; a module reset returns them to default.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      transmitDisable_q <= TX_DISABLE_RESET;
    end else if (moduleReset) begin
      transmitDisable_q <= TX_DISABLE_RESET;
    end else if (wrByteDone && !firstWr_q && ptr_q == REG_TX_DISABLE) begin
      transmitDisable_q <= shift_q[LANES-1:0];
    end
  end

  // Reading a power high byte freezes its low byte, so the pair never tears.
  for (genvar l = 0; l < LANES; l++) begin : gHold
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        lsbHold_q[l] <= 8'h00;
      end else if (loadRead && ptr_q == 8'(REG_RX_POWER + 2 * l)) begin
        lsbHold_q[l] <= powerHeld[l][7:0];
      end
    end
  end

  // Read data for the current pointer; unmapped offsets read as zero.
  always_comb begin
    readByte = 8'h00;
    if (ptr_q == REG_STATUS) begin
      readByte[STATUS_NOT_VALID_BIT] = initBusy_q;
    end else if (ptr_q == REG_LOS) begin
      readByte[LANES-1:0] = receiveSignalLost;
    end else if (ptr_q == REG_TX_DISABLE) begin
      readByte[LANES-1:0] = transmitDisable_q;
    end
    for (int l = 0; l < LANES; l++) begin
      if (ptr_q == 8'(REG_RX_POWER + 2 * l)) begin
        readByte = powerHeld[l][15:8];
      end else if (ptr_q == 8'(REG_RX_POWER + 2 * l + 1)) begin
        readByte = lsbHold_q[l];
      end
    end
  end

endmodule // mlsc_low_speed_ctrl

// [hdl/mlsc_pkg.sv]
// Shared constants, types and management memory map of the low-speed control block.
package mlsc_pkg;

  // Lane count and clock rate.
  localparam int LANES         = 4;
  localparam int CLK_PERIOD_NS = 40;

  // Least low time on the module reset pin that counts as a reset, rounded up to cycles.
  localparam int RESET_MIN_NS  = 2000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_W   = $clog2(RESET_MIN_CYC + 1);

  // Time the module needs to bring its settings up after a reset, rounded up to cycles.
  localparam int INIT_NS       = 20000;
  localparam int INIT_CYC      = (INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CNT_W    = $clog2(INIT_CYC);

  // Two-wire bus framing.
  localparam logic [6:0] DEV_ADDR  = 7'h50;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Management memory map, byte offsets.
  localparam logic [7:0] REG_STATUS     = 8'h02;
  localparam logic [7:0] REG_LOS        = 8'h03;
  localparam logic [7:0] REG_RX_POWER   = 8'h22;
  localparam logic [7:0] REG_TX_DISABLE = 8'h56;

  // Field positions and reset values.
  localparam int               STATUS_NOT_VALID_BIT = 0;
  localparam logic [LANES-1:0] TX_DISABLE_RESET     = 4'h0;
  localparam logic [LANES-1:0] LASER_OFF_RESET      = 4'hF;

  // Received power reading of one lane.
  typedef logic [15:0] mlsc_power_t;

  // Side-band and bus pins that arrive from outside the clock domain.
  typedef struct packed {
    logic scl;
    logic sda;
    logic selectN;
    logic resetN;
    logic lowPower;
  } mlsc_pins_t;

  localparam mlsc_pins_t PINS_RESET = '{scl: 1'b1, sda: 1'b1, selectN: 1'b1,
                                        resetN: 1'b1, lowPower: 1'b0};

  // Two-wire slave states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    BUS_IDLE   = 3'h0,
    BUS_DEVADR = 3'h1,
    BUS_ACKDEV = 3'h3,
    BUS_WRBYTE = 3'h2,
    BUS_ACKWR  = 3'h6,
    BUS_RDBYTE = 3'h7,
    BUS_ACKRD  = 3'h5
  } mlsc_bus_state_t;

endpackage

// [hdl/mlsc_pin_sync.sv]
// Three-stage pin synchroniser with a two-stage agreement filter per pin.
`timescale 1ns/100ps
module mlsc_pin_sync
  import mlsc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire mlsc_pins_t pinsRaw,
  output mlsc_pins_t      pinsStable
);

  localparam int W = $bits(mlsc_pins_t);
  localparam logic [W-1:0] RESET_BITS = PINS_RESET;

  logic [W-1:0] raw;
  logic [W-1:0] stable_q;

  assign raw        = pinsRaw;
  assign pinsStable = stable_q;

  // Each pin runs through three flops; the first is seen only by the second.
  for (genvar i = 0; i < W; i++) begin : gSync
    logic [2:0] stage_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        stage_q <= {3{RESET_BITS[i]}};
      end else begin
        stage_q <= {stage_q[1:0], raw[i]};
      end
    end

    // A new level is taken only once stages two and three agree, which drops single glitches.
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        stable_q[i] <= RESET_BITS[i];
      end else if (stage_q[2] == stage_q[1]) begin
        stable_q[i] <= stage_q[2];
      end
    end
  end

endmodule // mlsc_pin_sync

// [hdl/mlsc_diagnostic_monitor.sv]
// Per-lane received power capture and loss-of-signal detection with hysteresis.
`timescale 1ns/100ps
module mlsc_diagnostic_monitor
  import mlsc_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire mlsc_power_t [LANES-1:0] rxPower,
  input  wire mlsc_power_t             losAssertLevel,
  input  wire mlsc_power_t             losDeassertLevel,
  output mlsc_power_t [LANES-1:0]      powerHeld,
  output logic [LANES-1:0]             laneLost
);

  for (genvar l = 0; l < LANES; l++) begin : gLane
    // The reading is registered so the serial side always sees a settled value.
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        powerHeld[l] <= 16'h0000;
      end else begin
        powerHeld[l] <= rxPower[l];
      end
    end

    // Between the two levels the flag keeps its value, so a weak lane does not chatter.
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        laneLost[l] <= 1'b0;
      end else if (rxPower[l] < losAssertLevel) begin
        laneLost[l] <= 1'b1;
      end else if (rxPower[l] > losDeassertLevel) begin
        laneLost[l] <= 1'b0;
      end
    end
  end

endmodule // mlsc_diagnostic_monitor

// [dv/mlsc_low_speed_ctrl_assertions.sv]
// Concurrent checks on the ports of the low-speed control block.
`timescale 1ns/100ps
module mlsc_low_speed_ctrl_chk
  import mlsc_pkg::*;
(
  input wire logic                    sys_clk,
  input wire logic                    rst_b,
  input wire logic                    sclIn,
  input wire logic                    sdaIn,
  input wire logic                    sdaOeN,
  input wire logic                    moduleSelectN,
  input wire logic                    moduleResetN,
  input wire logic                    lowPowerLaserOff,
  input wire logic                    presenceN,
  input wire logic                    interruptOutN,
  input wire logic [LANES-1:0]        laserOff,
  input wire logic [LANES-1:0]        receiveSignalLost,
  input wire mlsc_power_t [LANES-1:0] rxPower,
  input wire mlsc_power_t             losAssertLevel,
  input wire mlsc_power_t             losDeassertLevel
);
  logic [9:0]       upCnt_q;
  logic [5:0]       rstLowCnt_q;
  logic [LANES-1:0] powerLow, powerHigh;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Cycles since power-up; it saturates so each compare point is met only once.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) upCnt_q <= 10'h000;
    else if (upCnt_q != 10'h3FF) upCnt_q <= upCnt_q + 10'h001;
  end

  // Length of the current low pulse on the module reset pin.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rstLowCnt_q <= 6'h00;
    else if (moduleResetN) rstLowCnt_q <= 6'h00;
    else if (rstLowCnt_q != 6'h3F) rstLowCnt_q <= rstLowCnt_q + 6'h01;
  end

  // Lanes below the assert level and above the release level.
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      powerLow[l] = rxPower[l] < losAssertLevel;
      powerHigh[l] = rxPower[l] > losDeassertLevel;
    end
  end

  presence_low_a: assert property (presenceN == 1'b0)
    else $error("presence line not low");
  lp_laser_off_a: assert property (lowPowerLaserOff [*6] |-> laserOff == 4'hF)
    else $error("lasers on in low power");
  los_drives_int_a: assert property ((|receiveSignalLost) [*2] |-> !interruptOutN)
    else $error("interrupt high during signal loss");
  los_set_a: assert property (|powerLow |=> (receiveSignalLost & $past(powerLow)) == $past(powerLow))
    else $error("weak lane not flagged");
  los_clear_a: assert property (|powerHigh |=> (receiveSignalLost & $past(powerHigh)) == 4'h0)
    else $error("strong lane still flagged");
  desel_release_a: assert property (moduleSelectN [*6] |-> sdaOeN)
    else $error("data driven while deselected");
  int_quiet_a: assert property (upCnt_q < 10'h190 && !(|receiveSignalLost)
    && !(|$past(receiveSignalLost)) |-> interruptOutN) else $error("early interrupt");
  power_up_int_a: assert property (upCnt_q == INIT_CYC + 4 |-> !interruptOutN)
    else $error("no completion interrupt after power-up");
  mod_reset_a: assert property (((!lowPowerLaserOff) [*6] ##0 (rstLowCnt_q == 6'h3C))
    |-> laserOff == TX_DISABLE_RESET) else $error("module reset kept settings");

  // Main scenarios that the bench should reach.
  cover property (|receiveSignalLost);
  cover property (rstLowCnt_q == 6'h3C);
  cover property (!sdaOeN);
endmodule // mlsc_low_speed_ctrl_chk

bind mlsc_low_speed_ctrl mlsc_low_speed_ctrl_chk chk (.sys_clk, .rst_b, .sclIn, .sdaIn,
  .sdaOeN, .moduleSelectN, .moduleResetN, .lowPowerLaserOff, .presenceN, .interruptOutN,
  .laserOff, .receiveSignalLost, .rxPower, .losAssertLevel, .losDeassertLevel);

// [dv/mlsc_host_model.sv]
// Behavioural host controller driving the two-wire management bus.
`timescale 1ns/100ps
module mlsc_host_model
  import mlsc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sdaIn,
  output logic      scl,
  output logic      sda
);
  // Both lines idle high; the clock stands still between frames.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // Every line change lands on a falling edge of the system clock.
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Five cycles low, three high; the answer comes four and a half cycles after the fall,
  // so the line is sampled at the end of the high phase.
  task automatic bitx(input logic b, output logic r);
    scl = 1'b0;
    tick(1);
    sda = b;
    tick(4);
    scl = 1'b1;
    tick(3);
    r = sdaIn;
  endtask

  // Repeated start or stop: data moves while the clock is high.
  task automatic cond(input logic a, input logic b);
    scl = 1'b0;
    tick(1);
    sda = a;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda = b;
    tick(4);
  endtask

  // A byte goes out MSB first; ack is high when the ninth bit is pulled low.
  task automatic sendB(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(v[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask

  // Pointer write and one data byte; ok means all three bytes were taken.
  task automatic wr(input logic [7:0] p, input logic [7:0] v, output logic ok);
    logic a0, a1, a2;
    sda = 1'b0;
    tick(4);
    sendB({DEV_ADDR, 1'b0}, a0);
    sendB(p, a1);
    sendB(v, a2);
    cond(1'b0, 1'b1);
    ok = a0 & a1 & a2;
  endtask

  // Pointer write, repeated start, one byte read, no-acknowledge and stop.
  task automatic rd(input logic [7:0] p, input logic [6:0] a, output logic [7:0] v,
                    output logic ok);
    logic a0, a1, a2, r;
    sda = 1'b0;
    tick(4);
    sendB({a, 1'b0}, a0);
    sendB(p, a1);
    cond(1'b1, 1'b0);
    sendB({a, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(1'b1, r);
    cond(1'b0, 1'b1);
    ok = a0 & a1 & a2;
  endtask
endmodule // mlsc_host_model

// [dv/testbench.sv]
// Self-checking bench for the low-speed control block with a host bus model.
`timescale 1ns/100ps
module testbench
  import mlsc_pkg::*;
;
  typedef struct packed {
    logic       lp;
    logic [3:0] tx;
    logic [3:0] exp;
  } mlsc_row_t;

  logic                    sys_clk, rst_b, scl, hostSda, sdaWire, sdaOut, sdaOeN, ok;
  logic                    moduleSelectN, moduleResetN, lowPowerLaserOff, presenceN;
  logic                    interruptOutN;
  logic [LANES-1:0]        laserOff, receiveSignalLost;
  mlsc_power_t [LANES-1:0] rxPower;
  mlsc_power_t             losAssertLevel, losDeassertLevel;
  logic [7:0]              d;
  int                      cyc, err_total, n_compared;
  mlsc_row_t               rows [5] = '{'{1'b0, 4'h5, 4'h5}, '{1'b1, 4'h5, 4'hF},
    '{1'b0, 4'hA, 4'hA}, '{1'b0, 4'hF, 4'hF}, '{1'b1, 4'h0, 4'hF}};

  // Open-drain data wire with its pull-up: low if either party pulls.
  assign sdaWire = hostSda & (sdaOeN | sdaOut);

  mlsc_low_speed_ctrl dut (.sys_clk, .rst_b, .sclIn(scl), .sdaIn(sdaWire), .sdaOut, .sdaOeN,
    .moduleSelectN, .moduleResetN, .lowPowerLaserOff, .presenceN, .interruptOutN, .laserOff,
    .receiveSignalLost, .rxPower, .losAssertLevel, .losDeassertLevel);
  mlsc_host_model host (.sys_clk, .sdaIn(sdaWire), .scl, .sda(hostSda));

  // System clock.
  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  end

  // One comparison, counted and reported on mismatch.
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait for the interrupt to fall, counting cycles.
  task automatic waitInt(output int c);
    c = 0;
    while (interruptOutN !== 1'b0 && c < 700) begin
      host.tick(1);
      c++;
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // The whole run needs roughly seven thousand cycles; this cuts a hang short.
  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    moduleSelectN = 1'b0;
    moduleResetN = 1'b1;
    lowPowerLaserOff = 1'b0;
    losAssertLevel = 16'h0040;
    losDeassertLevel = 16'h0080;
    rxPower = {LANES{16'h1000}};
    host.tick(5);
    chk("rstLaser", 8'h0F, 8'(laserOff));
    chk("rstInt", 8'h01, 8'(interruptOutN));
    chk("presence", 8'h00, 8'(presenceN));
    rst_b = 1'b1;
    waitInt(cyc);
    chk("upDone", 8'h01, 8'(cyc >= INIT_CYC && cyc <= INIT_CYC + 10));
    host.rd(REG_STATUS, DEV_ADDR, d, ok);
    chk("upStat", 8'h00, 8'(d[STATUS_NOT_VALID_BIT]));
    chk("intClr", 8'h01, 8'(interruptOutN));
    // Register writes against the low-power pin, each read back.
    foreach (rows[i]) begin
      lowPowerLaserOff = rows[i].lp;
      host.wr(REG_TX_DISABLE, {4'h0, rows[i].tx}, ok);
      chk("wrAck", 8'h01, 8'(ok));
      host.tick(8);
      chk("laserOff", 8'(rows[i].exp), 8'(laserOff));
      host.rd(REG_TX_DISABLE, DEV_ADDR, d, ok);
      chk("txRead", {4'h0, rows[i].tx}, d);
    end
    // Deselected traffic is ignored; a wrong address gets no answer.
    lowPowerLaserOff = 1'b0;
    moduleSelectN = 1'b1;
    host.wr(REG_TX_DISABLE, 8'h0F, ok);
    chk("selWrAck", 8'h00, 8'(ok));
    host.rd(REG_TX_DISABLE, DEV_ADDR, d, ok);
    chk("selRd", 8'hFF, d);
    moduleSelectN = 1'b0;
    host.tick(8);
    host.rd(REG_TX_DISABLE, DEV_ADDR ^ 7'h01, d, ok);
    chk("adrAck", 8'h00, 8'(ok));
    host.rd(REG_TX_DISABLE, DEV_ADDR, d, ok);
    chk("selKeep", 8'h00, d);
    // Lane 2 goes weak; the band between the levels holds the alarm.
    rxPower = {16'h2000, 16'h0010, 16'h1234, 16'h0100};
    host.tick(4);
    chk("los", 8'h04, 8'(receiveSignalLost));
    chk("losInt", 8'h00, 8'(interruptOutN));
    host.rd(REG_LOS, DEV_ADDR, d, ok);
    chk("losReg", 8'h04, d);
    host.rd(REG_RX_POWER + 8'h02, DEV_ADDR, d, ok);
    chk("pwrMsb", 8'h12, d);
    host.rd(REG_RX_POWER + 8'h03, DEV_ADDR, d, ok);
    chk("pwrLsb", 8'h34, d);
    rxPower[2] = 16'h0080;
    host.tick(4);
    chk("losHold", 8'h04, 8'(receiveSignalLost));
    rxPower[2] = 16'h0081;
    host.tick(4);
    chk("losClr", 8'h00, 8'(receiveSignalLost));
    chk("intOff", 8'h01, 8'(interruptOutN));
    // Raised levels flag every lane under them; the old levels clear them all again.
    losAssertLevel = 16'h1300;
    losDeassertLevel = 16'h1400;
    host.tick(4);
    chk("losLevel", 8'h07, 8'(receiveSignalLost));
    chk("losLevelInt", 8'h00, 8'(interruptOutN));
    losAssertLevel = 16'h0040;
    losDeassertLevel = 16'h0080;
    host.tick(4);
    chk("losRelease", 8'h00, 8'(receiveSignalLost));
    // A short reset pulse is ignored; a long one restores defaults.
    host.wr(REG_TX_DISABLE, 8'h03, ok);
    moduleResetN = 1'b0;
    host.tick(30);
    moduleResetN = 1'b1;
    host.tick(8);
    chk("shortRst", 8'h03, 8'(laserOff));
    moduleResetN = 1'b0;
    host.tick(70);
    chk("longRst", 8'(TX_DISABLE_RESET), 8'(laserOff));
    chk("rstIntHi", 8'h01, 8'(interruptOutN));
    moduleResetN = 1'b1;
    waitInt(cyc);
    chk("rstDone", 8'h01, 8'(cyc >= INIT_CYC && cyc <= INIT_CYC + 10));
    host.rd(REG_STATUS, DEV_ADDR, d, ok);
    chk("rstStat", 8'h00, 8'(d[STATUS_NOT_VALID_BIT]));
    test_done();
  end
endmodule // testbench
